// *** hw/linear_sensor_binned_readout.sv ***
// Purpose: Binned readout of a 1024-photodiode line with a Wishbone port.
// Assumes: All pins are synchronous to ref_clk; rstn is synchronous.
// Notes:   Photodiode levels are held in a local array written over the bus.

// ---------------------------------------------------------------------
// Output FIFO
// ---------------------------------------------------------------------
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   input  wire logic [WIDTH-1:0]         inData,
   input  wire logic                     inValid,
   output logic                          inReady,
   output logic [WIDTH-1:0]              outData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [$clog2(DEPTH):0]        level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   logic             push;
   logic             pop;

   assign level    = wrPtr_r - rdPtr_r;
   assign inReady  = (level != (AW+1)'(DEPTH));
   assign outValid = (level != '0);
   assign outData  = store[rdPtr_r[AW-1:0]];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         store[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule // sync_fifo

// ---------------------------------------------------------------------
// Readout top
// ---------------------------------------------------------------------
module linear_sensor_binned_readout
   import sensor_readout_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [11:0]   wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic [31:0]        wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          readoutStart,
   input  wire logic          sensorReset,
   input  wire logic          binSelLo,
   input  wire logic          binSelHi,
   input  wire logic          exposureGate,
   input  wire logic          pixelResetModeSel,
   output pixel_beat_t        pixOut,
   output logic               pixValid,
   input  wire logic          pixReady,
   output logic [AMP_COUNT-1:0] ampEnable,
   output logic               outAmpEnable,
   output logic               clocksRunning,
   output logic               standby,
   output logic               dynResetPulse,
   output logic [IDX_W-1:0]   dynResetIdx
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [1:0] binShiftOf(input logic hi, input logic lo);
      binShiftOf = {hi, lo};
   endfunction

   function automatic logic [PIX_W-1:0] binAverage(
      input logic [ROW_W-1:0] row,
      input logic [2:0]       lane,
      input logic [1:0]       shift
   );
      logic [PIX_W+2:0] sum;
      logic [3:0]       span;
      sum  = '0;
      span = 4'(4'h1 << shift);
      for (int i = 0; i < ROW_LANES; i++) begin
         if ((4'(i) >= {1'b0, lane}) && (4'(i) < ({1'b0, lane} + span))) begin
            sum = sum + (PIX_W+3)'(row[i*PIX_W +: PIX_W]);
         end
      end
      binAverage = PIX_W'(sum >> shift);
   endfunction

   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   logic [ROW_W-1:0]   pixMem [ROWS];
   logic [1:0]         ctrl_r;
   logic [15:0]        frames_r;
   logic               ack_r;
   logic [31:0]        rdData_r;
   logic               busReq;
   logic               memHit;
   logic [6:0]         memRow;
   logic               memHalf;
   logic [LEVEL_W-1:0] fifoLevel;
   logic               dynPrimed_r;
   logic [1:0]         shift_r;
   readout_state_t     state_r;
   readout_state_t     state_nxt;

   assign busReq   = wb_cyc_i & wb_stb_i & ~ack_r;
   assign memHit   = (wb_adr_i[11:10] == ADR_MEM_LO[11:10]);
   assign memRow   = wb_adr_i[9:3];
   assign memHalf  = wb_adr_i[2];
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdData_r;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= busReq;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (busReq & wb_we_i & memHit) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               pixMem[memRow][{memHalf, 2'(b), 3'h0} +: PIX_W] <=
                  wb_dat_i[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RESET;
      end else if (busReq & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == ADR_CTRL)) begin
         ctrl_r <= wb_dat_i[1:0];
      end else begin
         ctrl_r[CTRL_CLRCNT_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdData_r <= '0;
      end else if (busReq & ~wb_we_i) begin
         rdData_r <= '0;
         if (memHit) begin
            rdData_r <= pixMem[memRow][{memHalf, 5'h00} +: 32];
         end else if (wb_adr_i == ADR_CTRL) begin
            rdData_r <= {30'h0, ctrl_r};
         end else if (wb_adr_i == ADR_STATUS) begin
            rdData_r[ST_BUSY_BIT]    <= (state_r == ST_READ);
            rdData_r[ST_STANDBY_BIT] <= (state_r == ST_STANDBY);
            rdData_r[ST_SHIFT_LSB +: 2] <= shift_r;
            rdData_r[ST_INTEG_BIT]   <= ~sensorReset & exposureGate;
            rdData_r[ST_PRIMED_BIT]  <= dynPrimed_r;
            rdData_r[ST_LEVEL_LSB +: LEVEL_W] <= fifoLevel;
         end else if (wb_adr_i == ADR_FRAMES) begin
            rdData_r <= {16'h0, frames_r};
         end
      end
   end

   // ------------------------------------------------------------------
   // Readout sequencer
   // ------------------------------------------------------------------
   logic [IDX_W-1:0] outIdx_r;
   logic [IDX_W-1:0] lastIdx;
   logic [IDX_W-1:0] physIdx;
   logic             advance;
   logic             lastPixel;
   logic             standbyReq;
   logic             fifoRoom;
   logic             dynMode;
   pixel_beat_t      beat_r;
   logic             beatValid_r;
   logic [IDX_W-1:0] beatIdx_r;

   // The beat register sits ahead of the FIFO, so a free slot is kept for
   // it; a stalled sink pauses the line instead of dropping pixels.
   assign fifoRoom   = (fifoLevel < LEVEL_W'(FIFO_DEPTH - 1));
   assign standbyReq = sensorReset & readoutStart;
   assign dynMode    = pixelResetModeSel;
   assign lastIdx    = IDX_W'((PHYS_PIXELS >> shift_r) - 1);
   assign lastPixel  = (outIdx_r == lastIdx);
   assign advance    = (state_r == ST_READ) & fifoRoom;
   assign physIdx    = IDX_W'(outIdx_r << shift_r);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (standbyReq) begin
               state_nxt = ST_STANDBY;
            end else if (readoutStart & ~sensorReset
                         & ctrl_r[CTRL_ENABLE_BIT]) begin
               state_nxt = ST_READ;
            end
         end
         ST_READ: begin
            if (standbyReq) begin
               state_nxt = ST_STANDBY;
            end else if (sensorReset) begin
               state_nxt = ST_IDLE;
            end else if (advance & lastPixel & ~readoutStart) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_STANDBY: begin
            if (!standbyReq) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bin select is taken only outside ST_READ, so a change mid-frame
   // cannot alter the length of the frame already running.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         shift_r <= '0;
      end else if (state_r != ST_READ) begin
         shift_r <= binShiftOf(binSelHi, binSelLo);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         outIdx_r <= '0;
      end else if (sensorReset | (state_r != ST_READ)) begin
         outIdx_r <= '0;
      end else if (readoutStart) begin
         outIdx_r <= '0;
      end else if (advance) begin
         outIdx_r <= outIdx_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         beat_r      <= '0;
         beatValid_r <= 1'b0;
         beatIdx_r   <= '0;
      end else begin
         beatValid_r <= advance & ~sensorReset;
         if (advance) begin
            beat_r.value      <= binAverage(pixMem[physIdx[IDX_W-1:3]],
                                          physIdx[2:0], shift_r);
            beat_r.frameFirst <= (outIdx_r == '0);
            beat_r.frameLast  <= lastPixel & ~readoutStart;
            beat_r.videoValid <= ~dynMode | dynPrimed_r;
            beatIdx_r         <= outIdx_r;
         end
      end
   end

   // ------------------------------------------------------------------
   // Frame bookkeeping and dynamic reset
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         frames_r <= '0;
      end else if (advance & lastPixel & ~readoutStart & ~sensorReset) begin
         frames_r <= frames_r + 1'b1;
      end else if (ctrl_r[CTRL_CLRCNT_BIT]) begin
         frames_r <= '0;
      end
   end

   // The first frame after entering dynamic mode has integrated for an
   // unknown time, so its beats are marked as not valid video.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dynPrimed_r <= 1'b0;
      end else if (!dynMode) begin
         dynPrimed_r <= 1'b0;
      end else if (advance & lastPixel & ~readoutStart) begin
         dynPrimed_r <= 1'b1;
      end
   end

   // Each pixel is reset two cycles after the cycle in which it was read out.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dynResetPulse <= 1'b0;
         dynResetIdx   <= '0;
      end else begin
         dynResetPulse <= beatValid_r & dynMode;
         dynResetIdx   <= beatIdx_r;
      end
   end

   // ------------------------------------------------------------------
   // Power management
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ampEnable     <= '0;
         outAmpEnable  <= 1'b0;
         clocksRunning <= 1'b0;
         standby       <= 1'b0;
      end else begin
         standby       <= standbyReq;
         outAmpEnable  <= ~standbyReq;
         clocksRunning <= ~standbyReq & ~sensorReset;
         if (standbyReq) begin
            ampEnable <= '0;
         end else begin
            ampEnable <= AMP_COUNT'((9'h001 <<
                         (4'h8 >> binShiftOf(binSelHi, binSelLo)))
                         - 9'h001);
         end
      end
   end

   // ------------------------------------------------------------------
   // Output buffer
   // ------------------------------------------------------------------
   sync_fifo #(
      .WIDTH (BEAT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .inData   (beat_r),
      .inValid  (beatValid_r),
      .inReady  (),
      .outData  (pixOut),
      .outValid (pixValid),
      .outReady (pixReady),
      .level    (fifoLevel)
   );

endmodule // linear_sensor_binned_readout

// *** hw/sensor_readout_pkg.sv ***
// Purpose: Shared constants and types for the binned linear sensor readout.
// Assumes: A 40 MHz ref_clk, one binned pixel per clock during readout.
// Notes:   Offsets are Wishbone byte addresses.
package sensor_readout_pkg;

   // ------------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------------
   localparam int PHYS_PIXELS = 1024;
   localparam int PIX_W       = 8;
   localparam int IDX_W       = 10;
   localparam int ROW_LANES   = 8;
   localparam int ROWS        = PHYS_PIXELS / ROW_LANES;
   localparam int ROW_W       = ROW_LANES * PIX_W;
   localparam int AMP_COUNT   = 8;
   localparam int FIFO_DEPTH  = 16;
   localparam int LEVEL_W     = 5;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [11:0] ADR_CTRL   = 12'h000;
   localparam logic [11:0] ADR_STATUS = 12'h004;
   localparam logic [11:0] ADR_FRAMES = 12'h008;
   localparam logic [11:0] ADR_MEM_LO = 12'h800;
   localparam logic [1:0]  CTRL_RESET = 2'h1;
   localparam int CTRL_ENABLE_BIT  = 0;
   localparam int CTRL_CLRCNT_BIT  = 1;
   localparam int ST_BUSY_BIT      = 0;
   localparam int ST_STANDBY_BIT   = 1;
   localparam int ST_SHIFT_LSB     = 2;
   localparam int ST_INTEG_BIT     = 4;
   localparam int ST_PRIMED_BIT    = 5;
   localparam int ST_LEVEL_LSB     = 8;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_READ    = 3'h2,
      ST_STANDBY = 3'h4
   } readout_state_t;

   typedef struct packed {
      logic             frameFirst;
      logic             frameLast;
      logic             videoValid;
      logic [PIX_W-1:0] value;
   } pixel_beat_t;

   localparam int BEAT_W = $bits(pixel_beat_t);

endpackage : sensor_readout_pkg

// *** sim/sensor_readout_props.sv ***
// Purpose: Port-level assertions for the binned sensor readout.
// Assumes: One clock domain, synchronous active-low rstn.
// Notes:   Bound to the readout top from the bench top file.
module sensor_readout_props
   import sensor_readout_pkg::*;
(
   input wire logic                 ref_clk,
   input wire logic                 rstn,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire logic                 readoutStart,
   input wire logic                 sensorReset,
   input wire logic                 binSelLo,
   input wire logic                 binSelHi,
   input wire logic                 pixelResetModeSel,
   input wire pixel_beat_t          pixOut,
   input wire logic                 pixValid,
   input wire logic                 pixReady,
   input wire logic [AMP_COUNT-1:0] ampEnable,
   input wire logic                 outAmpEnable,
   input wire logic                 clocksRunning,
   input wire logic                 standby,
   input wire logic                 dynResetPulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("bus answer late");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("bus answer held");
   property p_amp_map;
      !standby && !(sensorReset && readoutStart)
         && $stable({binSelHi, binSelLo}) |=> ampEnable ==
         8'(32'h01030FFF >> (8 * $past({binSelHi, binSelLo})));
   endproperty
   a_amp_map: assert property (p_amp_map)
      else $error("amplifier enables wrong");
   property p_stby_in;
      sensorReset && readoutStart |-> ##[1:2] standby;
   endproperty
   a_stby_in: assert property (p_stby_in)
      else $error("standby not entered");
   property p_stby_off;
      standby |-> ampEnable == 8'h00 && !outAmpEnable && !clocksRunning;
   endproperty
   a_stby_off: assert property (p_stby_off)
      else $error("amplifier on in standby");
   property p_rst_clk;
      sensorReset [*2] |-> !clocksRunning;
   endproperty
   a_rst_clk: assert property (p_rst_clk)
      else $error("clocks run during reset");
   property p_hold;
      pixValid && !pixReady |=> pixValid && $stable(pixOut);
   endproperty
   a_hold: assert property (p_hold)
      else $error("pixel lost while stalled");
   property p_dyn;
      dynResetPulse |-> pixelResetModeSel;
   endproperty
   a_dyn: assert property (p_dyn)
      else $error("pixel reset outside dynamic mode");
   property p_video;
      pixValid && !pixelResetModeSel |-> pixOut.videoValid;
   endproperty
   a_video: assert property (p_video)
      else $error("invalid video in frame mode");
endmodule // sensor_readout_props

// *** sim/tb_linear_sensor_binned_readout.sv ***
// Purpose: Self-checking bench for the binned sensor readout.
// Assumes: 40 MHz ref_clk, photodiode bytes loaded over Wishbone.
// Notes:   Pixel byte n holds a pattern that differs per 256-block.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   num_errors++; $display("ERROR %s expected %0h seen %0h", nm, e, g); \
   end end
module tb_linear_sensor_binned_readout
   import sensor_readout_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, wb_ack_o, readoutStart = 1'b0, sensorReset = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic binSelLo = 1'b0, binSelHi = 1'b0, exposureGate = 1'b0;
   logic pixelResetModeSel = 1'b0, pixValid, pixReady, outAmpEnable;
   logic clocksRunning, standby, dynResetPulse;
   pixel_beat_t pixOut;
   logic [AMP_COUNT-1:0] ampEnable;
   logic [IDX_W-1:0] dynResetIdx;
   logic [1:0] readyMode = 2'h0;
   int num_errors = 0, tests_run = 0;
   always #12.5 ref_clk = ~ref_clk;
   linear_sensor_binned_readout dut (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .readoutStart, .sensorReset, .binSelLo, .binSelHi, .exposureGate,
      .pixelResetModeSel, .pixOut, .pixValid, .pixReady, .ampEnable,
      .outAmpEnable, .clocksRunning, .standby, .dynResetPulse, .dynResetIdx);
   video_sink_model sink (.ref_clk, .readyMode, .pixOut, .pixValid,
      .dynResetPulse, .pixReady);
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   function automatic logic [7:0] pat(input int n);
      return 8'(n) ^ {2'(n >> 8), 6'h00};
   endfunction
   task automatic wb(input logic we, input logic [11:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin @(posedge ref_clk); n++; end
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      `CHK("bus ack", 1'b1, wb_ack_o)
      `CHK("bus wait", 2, n)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      ticks(1);
   endtask
   // Expected pixel i is the floor mean of an aligned group of g bytes.
   task automatic run_frame(input logic [1:0] bs, input logic [1:0] rm,
                            input logic vv, input int st);
      int n, g, k;
      n = 1024 >> bs;
      g = 1 << bs;
      k = 0;
      sink.beats.delete();
      sink.stamps.delete();
      readyMode <= rm;
      binSelHi <= bs[1];
      binSelLo <= bs[0];
      ticks(2);
      readoutStart <= 1'b1;
      ticks(st);
      readoutStart <= 1'b0;
      while (sink.beats.size() < n + st - 1 && k < 6000) begin
         ticks(1);
         k++;
      end
      ticks(4);
      `CHK("amps", 8'(32'h01030FFF >> (8 * bs)), ampEnable)
      `CHK("beats", n + st - 1, sink.beats.size())
      for (int i = 0; i < n && i + st <= sink.beats.size(); i++) begin
         `CHK("pixel", 8'(pat(i * g) + ((g - 1) >> 1)),
            sink.beats[i + st - 1].value)
         `CHK("video valid", vv, sink.beats[i].videoValid)
         if (st == 1) `CHK("frame marks", {i == 0, i == n - 1},
            {sink.beats[i].frameFirst, sink.beats[i].frameLast})
      end
      if (st == 2) `CHK("repeat", sink.beats[1].value,
         sink.beats[0].value)
      if (rm == 2'h0 && st == 1) `CHK("span", n - 1,
         sink.stamps[n - 1] - sink.stamps[0])
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs;
      wb(1'b0, ADR_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h1, rd)
      wb(1'b0, 12'h00C, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      exposureGate <= 1'b1;
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK("integrating", 1'b1, rd[ST_INTEG_BIT])
      exposureGate <= 1'b0;
      wb(1'b1, ADR_CTRL, 32'h0);
      readoutStart <= 1'b1;
      ticks(1);
      readoutStart <= 1'b0;
      ticks(10);
      `CHK("disabled start", 1'b0, pixValid)
      wb(1'b1, ADR_CTRL, 32'h1);
   endtask
   task automatic t_standby;
      sensorReset <= 1'b1;
      readoutStart <= 1'b1;
      ticks(3);
      `CHK("standby", 1'b1, standby)
      `CHK("out amp", 1'b0, outAmpEnable)
      sensorReset <= 1'b0;
      readoutStart <= 1'b0;
      ticks(3);
      `CHK("standby exit", 2'h1, {standby, outAmpEnable})
   endtask
   task automatic t_abort;
      int k;
      k = 0;
      readyMode <= 2'h2;
      binSelHi <= 1'b0;
      binSelLo <= 1'b0;
      readoutStart <= 1'b1;
      ticks(1);
      readoutStart <= 1'b0;
      ticks(60);
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK("fifo full", 5'h10, rd[ST_LEVEL_LSB +: LEVEL_W])
      sensorReset <= 1'b1;
      ticks(3);
      `CHK("clocks held", 1'b0, clocksRunning)
      sensorReset <= 1'b0;
      readyMode <= 2'h0;
      while (pixValid !== 1'b0 && k < 100) begin
         ticks(1);
         k++;
      end
      `CHK("drained", 1'b0, pixValid)
      run_frame(2'h0, 2'h0, 1'b1, 1);
   endtask
   task automatic t_dynamic;
      int p0;
      pixelResetModeSel <= 1'b1;
      p0 = sink.pulses;
      run_frame(2'h3, 2'h0, 1'b0, 1);
      `CHK("pixel resets", 32'h80, sink.pulses - p0)
      `CHK("reset index", 10'h07F, dynResetIdx)
      run_frame(2'h3, 2'h0, 1'b1, 1);
      pixelResetModeSel <= 1'b0;
      ticks(2);
   endtask
   task automatic t_counters;
      wb(1'b0, ADR_FRAMES, 32'h0);
      `CHK("frames", 32'h8, rd)
      wb(1'b0, ADR_STATUS, 32'h0);
      `CHK("status", 6'h0C, rd[5:0])
      wb(1'b1, ADR_CTRL, 32'h3);
      wb(1'b0, ADR_FRAMES, 32'h0);
      `CHK("frames cleared", 32'h0, rd)
      wb(1'b0, ADR_CTRL, 32'h0);
      `CHK("ctrl self clear", 32'h1, rd)
   endtask
   task automatic end_sim;
      $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      $display("ERROR watchdog expected done seen timeout");
      end_sim;
   end
   initial begin
      ticks(20);
      rstn <= 1'b1;
      ticks(2);
      `CHK("reset amps", 8'hFF, ampEnable)
      `CHK("reset out", 2'h0, {standby, pixValid})
      t_regs;
      for (int w = 0; w < 256; w++) wb(1'b1, 12'(ADR_MEM_LO + 4 * w),
         {pat(4 * w + 3), pat(4 * w + 2), pat(4 * w + 1), pat(4 * w)});
      for (int b = 0; b < 4; b++) run_frame(2'(b), 2'(b == 3), 1'b1, 1);
      run_frame(2'h3, 2'h0, 1'b1, 2);
      t_standby;
      t_abort;
      t_dynamic;
      t_counters;
      end_sim;
   end
endmodule // tb_linear_sensor_binned_readout
bind linear_sensor_binned_readout sensor_readout_props u_props (.ref_clk,
   .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .readoutStart, .sensorReset,
   .binSelLo, .binSelHi, .pixelResetModeSel, .pixOut, .pixValid, .pixReady,
   .ampEnable, .outAmpEnable, .clocksRunning, .standby, .dynResetPulse);

// *** sim/video_sink_model.sv ***
// Purpose: Controller side that takes binned pixels off the output.
// Assumes: Bench selects readyMode between frames only.
// Notes:   Mode 1 stalls every other cycle, mode 2 refuses all beats.
module video_sink_model
   import sensor_readout_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic [1:0]  readyMode,
   input wire pixel_beat_t pixOut,
   input wire logic        pixValid,
   input wire logic        dynResetPulse,
   output logic            pixReady
);
   timeunit 1ns;
   timeprecision 1ps;
   pixel_beat_t beats[$];
   int          stamps[$];
   int          cycle = 0;
   int          pulses = 0;
   // A refusing sink lets the bench fill the FIFO to its limit.
   always @(posedge ref_clk) begin
      cycle <= cycle + 1;
      if (pixValid && pixReady) begin
         beats.push_back(pixOut);
         stamps.push_back(cycle);
      end
      if (dynResetPulse) pulses <= pulses + 1;
      pixReady <= readyMode == 2'h0 || (readyMode == 2'h1 && !pixReady);
   end
endmodule // video_sink_model
